/* File: logic/queue_flags_pkg.sv */
// Purpose: Shared constants for the dual-queue status flag block
// Assumes: 512-word queues, offsets of nine bits
// Notes:   Register offsets are byte addresses on the plain register port

package queue_flags_pkg;

   // ***********************************************************
   // Queue geometry
   // ***********************************************************
   localparam int          DEPTH      = 512;
   localparam int          ADDR_W     = 9;
   localparam int          PTR_W      = 10;
   localparam int          OFFSET_W   = 9;

   // ***********************************************************
   // Preset offsets loaded when a queue leaves reset; OFFSET_RST is loaded by rstn
   // ***********************************************************
   localparam logic [8:0]  PRESET_BOTH = 9'h040;
   localparam logic [8:0]  PRESET_HI   = 9'h010;
   localparam logic [8:0]  PRESET_LO   = 9'h008;
   localparam logic [8:0]  OFFSET_RST  = 9'h008;

   // ***********************************************************
   // Register port map
   // ***********************************************************
   localparam int          REG_AW      = 5;
   localparam logic [4:0]  REG_EMPTY_AB = 5'h00;
   localparam logic [4:0]  REG_FULL_AB  = 5'h04;
   localparam logic [4:0]  REG_EMPTY_BA = 5'h08;
   localparam logic [4:0]  REG_FULL_BA  = 5'h0C;
   localparam logic [4:0]  REG_STATUS   = 5'h10;

   // ***********************************************************
   // Pin synchroniser bit positions
   // ***********************************************************
   localparam int          PIN_W       = 10;
   localparam int          PIN_CLK_A   = 0;
   localparam int          PIN_CLK_B   = 1;
   localparam int          PIN_EN_A    = 2;
   localparam int          PIN_EN_B    = 3;
   localparam int          PIN_DIR_A   = 4;
   localparam int          PIN_DIR_B   = 5;
   localparam int          PIN_RST_AB  = 6;
   localparam int          PIN_RST_BA  = 7;
   localparam int          PIN_SEL_LO  = 8;
   localparam int          PIN_SEL_HI  = 9;

endpackage

/* File: logic/queue_flags.sv */
// Overview of operation
// RULE1: Every queue flag passes at least two flop stages on its port clock.
// RULE2: Port A flags update on port A clock, port B flags on port B.
// RULE3: Output-ready high means new word loaded; low ignores reads, keeps word.
// RULE4: Read pointer steps once per word moved to output register.
// RULE5: Recently written word loads and raises output-ready on third read edge.
// RULE6: A read edge too close after a write counts from the next edge.
// RULE7: Write pointer steps once per stored word.
// RULE8: Input-ready high means a free location; low ignores writes.
// RULE9: A freed location raises input-ready on the second write edge.
// RULE10: A write edge too close after a read counts from the next edge.
// RULE11: Port A ready_n shows not input-ready when direction high, else not output-ready.
// RULE12: Port B ready_n shows not input-ready when direction low, else not output-ready.
// RULE13: Port B almost-empty uses a-to-b offset; port A uses b-to-a offset.
// RULE14: Almost empty while memory holds offset words or fewer.
// RULE15: Word in output register counts as read; its location is free.
// RULE16: Almost-empty rises on second read edge after filling write.
// RULE17: Almost-empty sync counts from next edge if skew too short.
// RULE18: Port A almost-full uses a-to-b offset; port B uses b-to-a offset.
// RULE19: Almost full at depth minus offset or more; input-ready low at depth.
// RULE20: Almost-full rises on second write edge after the draining read.
// RULE21: Almost-full sync counts from next edge if skew too short.
// RULE22: Offsets range 1 to 508, nine bits, most significant bit first; code takes any nine-bit value in one parallel register write.
// RULE23: Queue reset release loads preset 64, 16 or 8 from selects.
// RULE24: After queue reset output-ready and almost-empty low, almost-full high.
//
// Purpose: Status flags and pointers of two opposing 512-word queues
// Assumes: Port clocks are slow pins sampled on mclk
// Notes:   Port clocks become one-cycle ticks after two-flop sampling

`timescale 1ns/1ps

module queue_side
   import queue_flags_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rstn,
   input  wire logic                clear,
   input  wire logic                wr_tick,
   input  wire logic                rd_tick,
   input  wire logic                wr_req,
   input  wire logic                rd_req,
   input  wire logic [OFFSET_W-1:0] empty_offset,
   input  wire logic [OFFSET_W-1:0] full_offset,
   output logic                     in_ready,
   output logic                     out_ready,
   output logic                     almost_empty_n,
   output logic                     almost_full_n,
   output logic [ADDR_W-1:0]        wr_addr,
   output logic                     wr_store,
   output logic [ADDR_W-1:0]        rd_addr,
   output logic                     out_load
);

   // ***********************************************************
   // Pointers and their crossings
   // ***********************************************************
   localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
   localparam logic [PTR_W-1:0] ONE_P   = PTR_W'(1);

   logic [PTR_W-1:0] wptr;
   logic [PTR_W-1:0] rptr;
   logic [PTR_W-1:0] ws1;
   logic [PTR_W-1:0] ws2;
   logic [PTR_W-1:0] rs1;
   logic [PTR_W-1:0] next_wptr;
   logic [PTR_W-1:0] next_rptr;
   logic [PTR_W-1:0] wr_level;
   logic [PTR_W-1:0] rd_level;
   logic             store;
   logic             avail;
   logic             load;
   logic             drop;

   assign store     = wr_tick & wr_req & in_ready;                // RULE8
   assign avail     = ws2 != rptr;
   assign load      = rd_tick & avail & (~out_ready | rd_req);    // RULE5
   assign drop      = rd_tick & out_ready & rd_req & ~avail;      // RULE3
   assign next_wptr = store ? wptr + ONE_P : wptr;
   assign next_rptr = load ? rptr + ONE_P : rptr;
   // Output register word already counts as read
   assign wr_level  = next_wptr - rs1;                            // RULE15
   assign rd_level  = ws1 - next_rptr;                            // RULE15

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wptr <= '0;
      end else if (clear) begin
         wptr <= '0;
      end else if (store) begin
         wptr <= wptr + ONE_P;                                    // RULE7
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rptr <= '0;
      end else if (clear) begin
         rptr <= '0;
      end else if (load) begin
         rptr <= rptr + ONE_P;                                    // RULE4
      end
   end

   // Write pointer seen by the read side, two stages on read ticks
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ws1 <= '0;
         ws2 <= '0;
      end else if (clear) begin
         ws1 <= '0;
         ws2 <= '0;
      end else if (rd_tick) begin
         ws1 <= wptr;                                             // RULE6 RULE17
         ws2 <= ws1;                                              // RULE1
      end
   end

   // Read pointer seen by the write side; flag flop is second stage
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rs1 <= '0;
      end else if (clear) begin
         rs1 <= '0;
      end else if (wr_tick) begin
         rs1 <= rptr;                                 // RULE10 RULE20 RULE21
      end
   end

   // ***********************************************************
   // Write side flags
   // ***********************************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         in_ready      <= 1'b0;
         almost_full_n <= 1'b1;
      end else if (clear) begin
         in_ready      <= 1'b0;
         almost_full_n <= 1'b1;                                   // RULE24
      end else if (wr_tick) begin
         in_ready      <= wr_level != DEPTH_P;                    // RULE9
         almost_full_n <= wr_level < DEPTH_P - {1'b0, full_offset}; // RULE19
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_addr  <= '0;
         wr_store <= 1'b0;
      end else begin
         wr_store <= store;
         if (store) begin
            wr_addr <= wptr[ADDR_W-1:0];
         end
      end
   end

   // ***********************************************************
   // Read side flags
   // ***********************************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_ready <= 1'b0;
      end else if (clear) begin
         out_ready <= 1'b0;                                       // RULE24
      end else if (load) begin
         out_ready <= 1'b1;                                       // RULE5
      end else if (drop) begin
         out_ready <= 1'b0;                                       // RULE3
      end
   end

   // Sampling ws1 gives the second read edge after the write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         almost_empty_n <= 1'b0;
      end else if (clear) begin
         almost_empty_n <= 1'b0;                                  // RULE24
      end else if (rd_tick) begin
         almost_empty_n <= rd_level > {1'b0, empty_offset}; // RULE14 RULE16
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_addr  <= '0;
         out_load <= 1'b0;
      end else begin
         out_load <= load;
         if (load) begin
            rd_addr <= rptr[ADDR_W-1:0];
         end
      end
   end

endmodule

module queue_flags
   import queue_flags_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              port_a_clock,
   input  wire logic              port_b_clock,
   input  wire logic              port_a_enable,
   input  wire logic              port_b_enable,
   input  wire logic              port_a_direction,
   input  wire logic              port_b_direction,
   input  wire logic              queue_ab_reset_n,
   input  wire logic              queue_ba_reset_n,
   input  wire logic              offset_select_lo,
   input  wire logic              offset_select_hi,
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic [31:0]            reg_rdata,
   output logic                   out_ready_a,
   output logic                   out_ready_b,
   output logic                   in_ready_a,
   output logic                   in_ready_b,
   output logic                   almost_empty_a_n,
   output logic                   almost_empty_b_n,
   output logic                   almost_full_a_n,
   output logic                   almost_full_b_n,
   output logic                   port_a_ready_n,
   output logic                   port_b_ready_n,
   output logic [ADDR_W-1:0]      ab_wr_addr,
   output logic                   ab_wr_store,
   output logic [ADDR_W-1:0]      ab_rd_addr,
   output logic                   ab_out_load,
   output logic [ADDR_W-1:0]      ba_wr_addr,
   output logic                   ba_wr_store,
   output logic [ADDR_W-1:0]      ba_rd_addr,
   output logic                   ba_out_load
);

   // ***********************************************************
   // Pin sampling
   // ***********************************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1;
   logic [PIN_W-1:0] pin_s2;
   logic [PIN_W-1:0] pin_prev;

   assign pin_raw = {offset_select_hi, offset_select_lo, queue_ba_reset_n,
                     queue_ab_reset_n, port_b_direction, port_a_direction,
                     port_b_enable, port_a_enable, port_b_clock,
                     port_a_clock};

   // Only pin_s2 and pin_prev are read; pin_s1 feeds nothing else
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_s1   <= '0;
         pin_s2   <= '0;
         pin_prev <= '0;
      end else begin
         pin_s1   <= pin_raw;                                     // RULE1
         pin_s2   <= pin_s1;
         pin_prev <= pin_s2;
      end
   end

   logic tick_a;
   logic tick_b;
   logic dir_a;
   logic dir_b;
   logic clear_ab;
   logic clear_ba;
   logic rise_ab;
   logic rise_ba;

   // Each port clock becomes a rising-edge tick on mclk
   assign tick_a   = pin_s2[PIN_CLK_A] & ~pin_prev[PIN_CLK_A];    // RULE2
   assign tick_b   = pin_s2[PIN_CLK_B] & ~pin_prev[PIN_CLK_B];    // RULE2
   assign dir_a    = pin_s2[PIN_DIR_A];
   assign dir_b    = pin_s2[PIN_DIR_B];
   assign clear_ab = ~pin_s2[PIN_RST_AB];
   assign clear_ba = ~pin_s2[PIN_RST_BA];
   assign rise_ab  = pin_s2[PIN_RST_AB] & ~pin_prev[PIN_RST_AB];
   assign rise_ba  = pin_s2[PIN_RST_BA] & ~pin_prev[PIN_RST_BA];

   // ***********************************************************
   // Offset registers
   // ***********************************************************
   logic [OFFSET_W-1:0] empty_offset_ab;
   logic [OFFSET_W-1:0] full_offset_ab;
   logic [OFFSET_W-1:0] empty_offset_ba;
   logic [OFFSET_W-1:0] full_offset_ba;

   // Both selects low keeps the programmed value
   function automatic logic [OFFSET_W-1:0] preset_offset(
      input logic                hi,
      input logic                lo,
      input logic [OFFSET_W-1:0] cur);
      logic [OFFSET_W-1:0] val;
      val = cur;
      if (hi && lo) begin
         val = PRESET_BOTH;                                       // RULE23
      end else if (hi) begin
         val = PRESET_HI;
      end else if (lo) begin
         val = PRESET_LO;
      end
      return val;
   endfunction

   logic wr_empty_ab;
   logic wr_full_ab;
   logic wr_empty_ba;
   logic wr_full_ba;

   assign wr_empty_ab = reg_write && reg_addr == REG_EMPTY_AB;
   assign wr_full_ab  = reg_write && reg_addr == REG_FULL_AB;
   assign wr_empty_ba = reg_write && reg_addr == REG_EMPTY_BA;
   assign wr_full_ba  = reg_write && reg_addr == REG_FULL_BA;

   // Preset at reset release wins over a software write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         empty_offset_ab <= OFFSET_RST;
         full_offset_ab  <= OFFSET_RST;
      end else if (rise_ab) begin
         empty_offset_ab <= preset_offset(pin_s2[PIN_SEL_HI],
                                          pin_s2[PIN_SEL_LO], empty_offset_ab);
         full_offset_ab  <= preset_offset(pin_s2[PIN_SEL_HI],
                                          pin_s2[PIN_SEL_LO], full_offset_ab);
      end else begin
         if (wr_empty_ab) begin
            empty_offset_ab <= reg_wdata[OFFSET_W-1:0];           // RULE22
         end
         if (wr_full_ab) begin
            full_offset_ab <= reg_wdata[OFFSET_W-1:0];            // RULE22
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         empty_offset_ba <= OFFSET_RST;
         full_offset_ba  <= OFFSET_RST;
      end else if (rise_ba) begin
         empty_offset_ba <= preset_offset(pin_s2[PIN_SEL_HI],
                                          pin_s2[PIN_SEL_LO], empty_offset_ba);
         full_offset_ba  <= preset_offset(pin_s2[PIN_SEL_HI],
                                          pin_s2[PIN_SEL_LO], full_offset_ba);
      end else begin
         if (wr_empty_ba) begin
            empty_offset_ba <= reg_wdata[OFFSET_W-1:0];
         end
         if (wr_full_ba) begin
            full_offset_ba <= reg_wdata[OFFSET_W-1:0];
         end
      end
   end

   // ***********************************************************
   // Queues
   // ***********************************************************
   logic a_write;
   logic a_read;
   logic b_write;
   logic b_read;

   assign a_write = pin_s2[PIN_EN_A] & dir_a;
   assign a_read  = pin_s2[PIN_EN_A] & ~dir_a;
   assign b_write = pin_s2[PIN_EN_B] & ~dir_b;
   assign b_read  = pin_s2[PIN_EN_B] & dir_b;

   queue_side u_queue_a_to_b (
      .mclk           (mclk),
      .rstn           (rstn),
      .clear          (clear_ab),
      .wr_tick        (tick_a),
      .rd_tick        (tick_b),
      .wr_req         (a_write),
      .rd_req         (b_read),
      .empty_offset   (empty_offset_ab),                          // RULE13
      .full_offset    (full_offset_ab),                           // RULE18
      .in_ready       (in_ready_a),
      .out_ready      (out_ready_b),
      .almost_empty_n (almost_empty_b_n),
      .almost_full_n  (almost_full_a_n),
      .wr_addr        (ab_wr_addr),
      .wr_store       (ab_wr_store),
      .rd_addr        (ab_rd_addr),
      .out_load       (ab_out_load)
   );

   queue_side u_queue_b_to_a (
      .mclk           (mclk),
      .rstn           (rstn),
      .clear          (clear_ba),
      .wr_tick        (tick_b),
      .rd_tick        (tick_a),
      .wr_req         (b_write),
      .rd_req         (a_read),
      .empty_offset   (empty_offset_ba),                          // RULE13
      .full_offset    (full_offset_ba),                           // RULE18
      .in_ready       (in_ready_b),
      .out_ready      (out_ready_a),
      .almost_empty_n (almost_empty_a_n),
      .almost_full_n  (almost_full_b_n),
      .wr_addr        (ba_wr_addr),
      .wr_store       (ba_wr_store),
      .rd_addr        (ba_rd_addr),
      .out_load       (ba_out_load)
   );

   // ***********************************************************
   // Ready outputs and register reads
   // ***********************************************************
   assign port_a_ready_n = dir_a ? ~in_ready_a : ~out_ready_a;    // RULE11
   assign port_b_ready_n = dir_b ? ~out_ready_b : ~in_ready_b;    // RULE12

   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      case (reg_addr)
         REG_EMPTY_AB: next_rdata = {23'h000000, empty_offset_ab};
         REG_FULL_AB:  next_rdata = {23'h000000, full_offset_ab};
         REG_EMPTY_BA: next_rdata = {23'h000000, empty_offset_ba};
         REG_FULL_BA:  next_rdata = {23'h000000, full_offset_ba};
         REG_STATUS:   next_rdata = {24'h000000,
                                     in_ready_b, out_ready_b,
                                     almost_full_b_n, almost_empty_b_n,
                                     in_ready_a, out_ready_a,
                                     almost_full_a_n, almost_empty_a_n};
         default:      next_rdata = '0;
      endcase
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

/* File: testbench/queue_flags_sva.sv */
// Purpose: Port-level checks of the queue flag block
// Assumes: Only the a-to-b pointers are tracked
// Notes:   Repetition counts cover the two-flop pin synchroniser lag
`timescale 1ns/1ps
module queue_flags_sva
   import queue_flags_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic              port_a_direction,
   input wire logic              port_b_direction,
   input wire logic              port_b_enable,
   input wire logic              queue_ab_reset_n,
   input wire logic              in_ready_a,
   input wire logic              out_ready_a,
   input wire logic              in_ready_b,
   input wire logic              out_ready_b,
   input wire logic              almost_empty_b_n,
   input wire logic              almost_full_a_n,
   input wire logic              port_a_ready_n,
   input wire logic              port_b_ready_n,
   input wire logic [ADDR_W-1:0] ab_wr_addr,
   input wire logic              ab_wr_store,
   input wire logic [ADDR_W-1:0] ab_rd_addr,
   input wire logic              ab_out_load
);
   // ***********************************************************
   // Expected pointers, cleared by either reset
   // ***********************************************************
   logic [ADDR_W-1:0] exp_wr;
   logic [ADDR_W-1:0] exp_rd;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         exp_wr <= '0;
         exp_rd <= '0;
      end else if (!queue_ab_reset_n) begin
         exp_wr <= '0;
         exp_rd <= '0;
      end else begin
         if (ab_wr_store) exp_wr <= ab_wr_addr + 1'h1;
         if (ab_out_load) exp_rd <= ab_rd_addr + 1'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_store_when_ready:
   assert property ((!in_ready_a)[*8] |-> !ab_wr_store) else $error("store while full");
   a_wr_addr_step:
   assert property (ab_wr_store |-> ab_wr_addr == exp_wr) else $error("write pointer skip");
   a_rd_addr_step:
   assert property (ab_out_load |-> ab_rd_addr == exp_rd) else $error("read pointer skip");
   a_load_with_ready:
   assert property ($rose(out_ready_b) |-> ab_out_load) else $error("ready without load");
   a_no_idle_load:
   assert property ((out_ready_b && !port_b_enable)[*8] |-> !ab_out_load)
      else $error("load without read");
   a_full_at_stop:
   assert property ($fell(in_ready_a) && queue_ab_reset_n |-> !almost_full_a_n)
      else $error("full but not almost full");
   a_qreset_flags:
   assert property ((!queue_ab_reset_n)[*6] |-> !out_ready_b && !almost_empty_b_n
      && almost_full_a_n) else $error("queue reset flags");
   a_ready_a_write:
   assert property (port_a_direction[*4] |-> port_a_ready_n == !in_ready_a)
      else $error("port a ready write");
   a_ready_a_read:
   assert property ((!port_a_direction)[*4] |-> port_a_ready_n == !out_ready_a)
      else $error("port a ready read");
   a_ready_b_write:
   assert property ((!port_b_direction)[*4] |-> port_b_ready_n == !in_ready_b)
      else $error("port b ready write");
   a_ready_b_read:
   assert property (port_b_direction[*4] |-> port_b_ready_n == !out_ready_b)
      else $error("port b ready read");
endmodule
bind queue_flags queue_flags_sva chk (.mclk(mclk), .rstn(rstn),
   .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
   .port_b_enable(port_b_enable), .queue_ab_reset_n(queue_ab_reset_n),
   .in_ready_a(in_ready_a), .out_ready_a(out_ready_a), .in_ready_b(in_ready_b),
   .out_ready_b(out_ready_b), .almost_empty_b_n(almost_empty_b_n),
   .almost_full_a_n(almost_full_a_n), .port_a_ready_n(port_a_ready_n),
   .port_b_ready_n(port_b_ready_n), .ab_wr_addr(ab_wr_addr),
   .ab_wr_store(ab_wr_store), .ab_rd_addr(ab_rd_addr),
   .ab_out_load(ab_out_load));

/* File: testbench/port_agent.sv */
// Purpose: Far-side port controller with free-running port clock
// Assumes: Half period counted in mclk cycles
// Notes:   Enable moves only on the mclk edge where the port clock falls, for setup margin
`timescale 1ns/1ps
module port_agent #(
   parameter int HALF = 8
) (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic want,
   output logic      pclk,
   output logic      en
);
   int cnt;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt  <= 0;
         pclk <= 1'h0;
         en   <= 1'h0;
      end else if (cnt == HALF - 1) begin
         cnt  <= 0;
         pclk <= !pclk;
         if (pclk) en <= want;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench of the queue flag block
// Assumes: Port A writes queue_a_to_b, port B reads it
// Notes:   Port clocks are slow against mclk so the sync lag stays small
`timescale 1ns/1ps
module tb_top import queue_flags_pkg::*;;
   logic        mclk, rstn, pclk_a, pclk_b, en_a, en_b, want_a, want_b;
   logic        dir_a, dir_b, qab_n, qba_n, sel_lo, sel_hi;
   logic [4:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        reg_write, reg_read, or_b, ir_a, ae_b, af_a, rdy_a, rdy_b;
   logic        st, ld;
   logic [8:0]  rd_addr;
   int          bad_count, n_compared, n_st, n_ld, cycles;
   logic [1:0]  sels [3] = '{2'h3, 2'h2, 2'h1};
   logic [8:0]  pres [3] = '{9'h040, 9'h010, 9'h008};
   queue_flags DUT (.mclk(mclk), .rstn(rstn), .port_a_clock(pclk_a),
      .port_b_clock(pclk_b), .port_a_enable(en_a), .port_b_enable(en_b),
      .port_a_direction(dir_a), .port_b_direction(dir_b),
      .queue_ab_reset_n(qab_n), .queue_ba_reset_n(qba_n),
      .offset_select_lo(sel_lo), .offset_select_hi(sel_hi),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .out_ready_a(),
      .out_ready_b(or_b), .in_ready_a(ir_a), .in_ready_b(),
      .almost_empty_a_n(), .almost_empty_b_n(ae_b), .almost_full_a_n(af_a),
      .almost_full_b_n(), .port_a_ready_n(rdy_a), .port_b_ready_n(rdy_b),
      .ab_wr_addr(), .ab_wr_store(st), .ab_rd_addr(rd_addr),
      .ab_out_load(ld), .ba_wr_addr(), .ba_wr_store(), .ba_rd_addr(),
      .ba_out_load());
   port_agent #(.HALF(8)) side_a (.mclk(mclk), .rstn(rstn), .want(want_a),
      .pclk(pclk_a), .en(en_a));
   port_agent #(.HALF(7)) side_b (.mclk(mclk), .rstn(rstn), .want(want_b),
      .pclk(pclk_b), .en(en_b));
   // ***********************************************************
   // Clock, event counters and hang limit
   // ***********************************************************
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (st === 1'h1) n_st <= n_st + 1;
      if (ld === 1'h1) n_ld <= n_ld + 1;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge mclk);
      reg_write <= 1'h0;
   endtask
   task automatic reg_rd(input logic [4:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge mclk);
      reg_read <= 1'h0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Holds the enable until n more events; stalls past the bound are legal
   task automatic push(input int n, input bit side_b_read);
      int t;
      t = (side_b_read ? n_ld : n_st) + n;
      if (side_b_read) want_b <= 1'h1;
      else want_a <= 1'h1;
      for (int i = 0; i < 20 * n + 100; i++) begin
         @(posedge mclk);
         if ((side_b_read ? n_ld : n_st) >= t) break;
      end
      want_a <= 1'h0;
      want_b <= 1'h0;
      repeat (80) @(posedge mclk);
   endtask
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      {rstn, want_a, want_b, sel_lo, sel_hi, reg_write, reg_read} = '0;
      {dir_a, dir_b, qab_n, qba_n} = 4'hF;
      {reg_addr, reg_wdata, bad_count, n_compared, n_st, n_ld, cycles} = '0;
      repeat (2) @(posedge mclk);
      rstn <= 1'h1;
      repeat (4) @(posedge mclk);
      chk(af_a, 1'h1);
      chk(or_b, 1'h0);
      for (int i = 0; i < 3; i++) begin
         {sel_hi, sel_lo} <= sels[i];
         qab_n <= 1'h0;
         repeat (8) @(posedge mclk);
         chk(ae_b, 1'h0);
         qab_n <= 1'h1;
         repeat (8) @(posedge mclk);
         {sel_hi, sel_lo} <= 2'h0;
         reg_rd(REG_EMPTY_AB, {23'h0, pres[i]});
         reg_rd(REG_FULL_AB, {23'h0, pres[i]});
      end
      reg_wr(REG_EMPTY_AB, 32'h2);
      reg_wr(REG_FULL_AB, 32'h4);
      reg_rd(REG_EMPTY_AB, 32'h2);
      reg_rd(REG_FULL_AB, 32'h4);
      reg_rd(5'h14, 32'h0);
      repeat (40) @(posedge mclk);
      reg_rd(REG_STATUS, 32'hAA);
      push(1, 0);
      chk(or_b, 1'h1);
      chk(rd_addr, 9'h000);
      chk(ae_b, 1'h0);
      push(2, 0);
      chk(ae_b, 1'h0);
      push(1, 0);
      chk(ae_b, 1'h1);
      push(600, 0);
      chk(n_st, 32'h201);
      chk(ir_a, 1'h0);
      chk(af_a, 1'h0);
      chk(rdy_a, 1'h1);
      push(1, 1);
      chk(rd_addr, 9'h001);
      chk(ir_a, 1'h1);
      chk(af_a, 1'h0);
      push(4, 1);
      chk(af_a, 1'h1);
      chk(rdy_b, 1'h0);
      end_sim();
   end
endmodule
